// file: src/rsm_top.v
// Reset strap loader, mode outputs and keyed base register unlock
`timescale 1ns/10ps
`include "rsm_defines.vh"

module rsm_top (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [2:0]  cfg_strap,
  input  wire        bus_width_strap,
  input  wire        base_unlock_pin_n,
  input  wire        host_req,
  input  wire        host_wr,
  input  wire [23:0] host_addr,
  input  wire [3:0]  host_fc,
  input  wire [3:0]  host_be,
  input  wire        host_burst,
  input  wire [31:0] host_wdata,
  output reg         host_ack,
  output reg         host_err,
  output reg  [31:0] host_rdata,
  output reg         slave_mode_r,
  output reg         core_enable_r,
  output reg  [1:0]  boot_cs_width_r,
  output reg         base_relocated_r,
  output reg         bus_width16_r,
  output reg         low_lanes_unused_r,
  output reg         bus_req_oe_r,
  output reg         bus_grant_oe_r,
  output reg         dma_bus_allow_r,
  output reg         unlock_sel_r
);

  // ****************************************************************
  // Strap capture
  // ****************************************************************

  reg  [2:0]  cfg_r;
  reg         width_r;
  reg         in_reset_r;
  wire        dec_slave;
  wire [1:0]  dec_cs;
  wire        dec_reloc;
  wire        dec_arb_rev;

  // Track first cycle after reset release; capture straps there
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  // Straps taken once at release, ignored thereafter
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r   <= 3'h0;
      width_r <= 1'b1;
    end else if (in_reset_r) begin
      cfg_r   <= cfg_strap;
      width_r <= bus_width_strap;
    end
  end

  rsm_strap_decode u_dec (
    .cfg            (cfg_r),
    .slave_mode     (dec_slave),
    .boot_cs_width  (dec_cs),
    .base_relocated (dec_reloc),
    .arb_reversed   (dec_arb_rev)
  );

  // ****************************************************************
  // Mode outputs
  // ****************************************************************

  // Registered copies of decoded mode
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slave_mode_r       <= 1'b0;
      core_enable_r      <= 1'b0;
      boot_cs_width_r    <= `RSM_CS_OFF;
      base_relocated_r   <= 1'b0;
      bus_width16_r      <= 1'b0;
      low_lanes_unused_r <= 1'b0;
      bus_req_oe_r       <= 1'b0;
      bus_grant_oe_r     <= 1'b0;
      dma_bus_allow_r    <= 1'b0;
    end else begin
      slave_mode_r       <= dec_slave;
      core_enable_r      <= ~dec_slave;
      boot_cs_width_r    <= dec_cs;
      base_relocated_r   <= dec_reloc;
      bus_width16_r      <= ~width_r;
      low_lanes_unused_r <= ~width_r;
      // Slave: request out/grant in, unless companion
      bus_req_oe_r       <= dec_slave & ~dec_arb_rev;
      bus_grant_oe_r     <= ~dec_slave | dec_arb_rev;
      dma_bus_allow_r    <= 1'b1;
    end
  end

  // ****************************************************************
  // Register access
  // ****************************************************************

  wire        cpu_space;
  wire        hit_unlock;
  wire        hit_base;
  wire        base_open;
  wire        base_wr;
  wire        low_byte_wr;
  wire [31:0] base_q;
  wire        burst_bad;

  assign cpu_space  = (host_fc == `RSM_FC_CPU);
  // Unlock decoded only when relocation active
  assign hit_unlock = cpu_space && base_relocated_r &&
                      (host_addr == `RSM_ADDR_UNLOCK);
  assign hit_base   = base_relocated_r ?
                      (cpu_space &&
                       host_addr == `RSM_ADDR_BASE_ALT) :
                      (cpu_space &&
                       host_addr == `RSM_ADDR_BASE_DEF);
  // Relocated base opens only after unlock
  assign base_open  = ~base_relocated_r | unlock_sel_r;
  assign burst_bad  = host_burst & slave_mode_r;
  assign base_wr    = host_req & host_wr & hit_base & base_open &
                      ~burst_bad & ~in_reset_r;

  rsm_base_reg u_base (
    .core_clk    (core_clk),
    .rst         (rst),
    .wr_en       (base_wr),
    .wr_be       (host_be),
    .wr_data     (host_wdata),
    .base_r      (base_q),
    .low_byte_wr (low_byte_wr)
  );

  // Unlock select bit: set by keyed write, cleared by low byte write
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unlock_sel_r <= 1'b0;
    end else if (host_req && host_wr && hit_unlock && !burst_bad &&
                 host_be[3] && host_wdata[`RSM_UNLOCK_SEL_BIT] &&
                 !base_unlock_pin_n) begin
      unlock_sel_r <= 1'b1;
    end else if (low_byte_wr && base_relocated_r) begin
      unlock_sel_r <= 1'b0;
    end
  end

  // One-cycle answer to every request
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_ack   <= 1'b0;
      host_err   <= 1'b0;
      host_rdata <= 32'h00000000;
    end else begin
      host_ack   <= 1'b0;
      host_err   <= 1'b0;
      host_rdata <= 32'h00000000;
      if (host_req) begin
        if (burst_bad || in_reset_r) begin
          host_err <= 1'b1;
        end else if (hit_base && base_open) begin
          host_ack <= 1'b1;
          if (!host_wr) begin
            host_rdata <= base_q;
          end
        end else if (hit_unlock) begin
          host_ack <= 1'b1;
          if (!host_wr) begin
            host_rdata <= {unlock_sel_r, 31'h00000000};
          end
        end else begin
          host_err <= 1'b1;
        end
      end
    end
  end

endmodule

// file: src/rsm_defines.vh
// Constants for the reset strap mode and base unlock block
// Behaviour
// - Sample three straps on first clock after reset release, pick mode
// - 000: slave, 8-bit boot select, default base
// - 001: slave, 32-bit, request out, grant in
// - 010: slave, 16-bit boot select, default base
// - 011: companion slave, 32-bit, request in, grant out
// - 100: normal, core on, 32-bit boot select
// - 101: normal, core on, 16-bit boot select
// - 110: slave, boot select off, base relocated
// - 111: normal, core on, 8-bit boot select
// - Width strap low: 16-bit bus, low lines unused
// - 16-bit bus uses upper lines, dynamic sizing kept
// - Width strap pulled up: default 32-bit bus
// - Slave mode disables core, DMA still owns bus
// - Slave on asynchronous host bus refuses bursts
// - Relocated base refused until valid unlock
// - Slave with boot select: no unlock needed
// - Decode unlock fixed, relocated base in function code 111
// - Unlock needs bit 31 written, pin low
// - Low byte base write relocks access
// - Base register reads zero after reset
`ifndef RSM_DEFINES_VH
`define RSM_DEFINES_VH

// Register addresses
`define RSM_ADDR_BASE_DEF   24'h03ff00
`define RSM_ADDR_BASE_ALT   24'h03ff04
`define RSM_ADDR_UNLOCK     24'h03ff08

// Field positions and values
`define RSM_UNLOCK_SEL_BIT  31
`define RSM_FC_CPU          4'h7
`define RSM_BASE_RESET      32'h00000000
`define RSM_BASE_WMASK      32'hffffe3ff

// Strap codes
`define RSM_CFG_SLV8        3'h0
`define RSM_CFG_SLV32       3'h1
`define RSM_CFG_SLV16       3'h2
`define RSM_CFG_COMP32      3'h3
`define RSM_CFG_NRM32       3'h4
`define RSM_CFG_NRM16       3'h5
`define RSM_CFG_SLVOFF      3'h6
`define RSM_CFG_NRM8        3'h7

// Boot select width codes
`define RSM_CS_OFF          2'h0
`define RSM_CS_8            2'h1
`define RSM_CS_16           2'h2
`define RSM_CS_32           2'h3

`endif

// file: src/rsm_strap_decode.v
// Strap decoder: turns latched strap value into operating mode
`timescale 1ns/10ps
`include "rsm_defines.vh"

module rsm_strap_decode (
  input  wire [2:0] cfg,
  output reg        slave_mode,
  output reg  [1:0] boot_cs_width,
  output reg        base_relocated,
  output reg        arb_reversed
);

  // Mode table
  always @* begin
    slave_mode     = 1'b1;
    boot_cs_width  = `RSM_CS_8;
    base_relocated = 1'b0;
    arb_reversed   = 1'b0;
    case (cfg)
      `RSM_CFG_SLV8: begin
        boot_cs_width = `RSM_CS_8;
      end
      `RSM_CFG_SLV32: begin
        boot_cs_width = `RSM_CS_32;
      end
      `RSM_CFG_SLV16: begin
        boot_cs_width = `RSM_CS_16;
      end
      `RSM_CFG_COMP32: begin
        boot_cs_width = `RSM_CS_32;
        arb_reversed  = 1'b1;
      end
      `RSM_CFG_NRM32: begin
        slave_mode    = 1'b0;
        boot_cs_width = `RSM_CS_32;
      end
      `RSM_CFG_NRM16: begin
        slave_mode    = 1'b0;
        boot_cs_width = `RSM_CS_16;
      end
      `RSM_CFG_SLVOFF: begin
        boot_cs_width  = `RSM_CS_OFF;
        base_relocated = 1'b1;
      end
      `RSM_CFG_NRM8: begin
        slave_mode    = 1'b0;
        boot_cs_width = `RSM_CS_8;
      end
      default: begin
        slave_mode = 1'b1;
      end
    endcase
  end

endmodule

// file: src/rsm_base_reg.v
// Module base register with byte writes and low-byte write pulse
`timescale 1ns/10ps
`include "rsm_defines.vh"

module rsm_base_reg (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [3:0]  wr_be,
  input  wire [31:0] wr_data,
  output reg  [31:0] base_r,
  output wire        low_byte_wr
);

  wire [31:0] base_nxt;
  wire [31:0] wmask;
  genvar      i;

  // Writable bit mask, reserved bits cleared
  assign wmask = `RSM_BASE_WMASK;

  // Per-lane merge, reserved bits held at zero
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      assign base_nxt[i*8 +: 8] = (wr_en && wr_be[i]) ?
        (wr_data[i*8 +: 8] & wmask[i*8 +: 8]) :
        base_r[i*8 +: 8];
    end
  endgenerate

  assign low_byte_wr = wr_en & wr_be[0];

  // Register, zero after reset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_r <= `RSM_BASE_RESET;
    end else begin
      base_r <= base_nxt;
    end
  end

endmodule

// file: dv/rsm_top_asserts.sv
// Concurrent checks on the strap loader and unlock ports
`timescale 1ns/10ps
module rsm_top_asserts (
  input logic        core_clk, rst, host_req, host_wr, host_burst,
  input logic        base_unlock_pin_n, host_ack, host_err,
  input logic        slave_mode_r, core_enable_r, base_relocated_r,
  input logic        unlock_sel_r,
  input logic [23:0] host_addr,
  input logic [3:0]  host_fc, host_be,
  input logic [1:0]  boot_cs_width_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] live_r;
  // Marks cycles where latched modes are settled
  always @(posedge core_clk or posedge rst)
    if (rst) live_r <= 2'h0;
    else live_r <= {live_r[0], 1'h1};
  a_core_vs_slave: assert property (
    live_r[1] |-> core_enable_r != slave_mode_r)
    else $error("core enable not inverse of slave");
  a_reloc_mode: assert property (
    live_r[1] && base_relocated_r |->
    slave_mode_r && boot_cs_width_r == 2'h0)
    else $error("relocated outside slave select off");
  a_modes_held: assert property (
    live_r[1] && $past(live_r[1]) |->
    $stable({slave_mode_r, boot_cs_width_r, base_relocated_r}))
    else $error("mode changed after reset");
  a_burst_refused: assert property (
    host_req && host_burst && slave_mode_r |=> host_err && !host_ack)
    else $error("slave burst taken");
  a_lock_refused: assert property (
    host_req && host_addr == 24'h03ff04 && base_relocated_r &&
    !unlock_sel_r |=> host_err)
    else $error("locked base reached");
  a_fc_decode: assert property (
    host_req && host_fc != 4'h7 |=> host_err)
    else $error("wrong space decoded");
  a_unlock_cause: assert property (
    $rose(unlock_sel_r) |-> $past(host_req) && $past(host_wr) &&
    !$past(base_unlock_pin_n) && $past(host_addr) == 24'h03ff08)
    else $error("unlock without keyed write");
  a_relock_low: assert property (
    unlock_sel_r && host_req && host_wr && !host_burst &&
    host_addr == 24'h03ff04 && host_fc == 4'h7 && host_be[0]
    |=> host_ack && !unlock_sel_r)
    else $error("no relock");
endmodule
bind rsm_top rsm_top_asserts rsm_top_asserts_i (.core_clk, .rst, .host_req,
  .host_wr, .host_burst, .base_unlock_pin_n, .host_ack, .host_err,
  .slave_mode_r, .core_enable_r, .base_relocated_r, .unlock_sel_r,
  .host_addr, .host_fc, .host_be, .boot_cs_width_r);

// file: dv/rsm_host_model.sv
// Host master model for the register bus of the block
`timescale 1ns/10ps
module rsm_host_model (
  input  logic        core_clk, host_ack, host_err,
  input  logic [31:0] host_rdata,
  output logic        host_req, host_wr, host_burst, base_unlock_pin_n,
  output logic [23:0] host_addr,
  output logic [3:0]  host_fc, host_be,
  output logic [31:0] host_wdata
);
  // Unlock pin wired to data line 0, pulled high otherwise
  assign base_unlock_pin_n = !(host_req && host_addr == 24'h03ff08)
                             | host_wdata[0];
  initial begin
    {host_req, host_wr, host_burst, host_addr} = 27'h0;
    {host_fc, host_be, host_wdata} = 40'h0;
  end
  // One request pulse, answer taken one cycle after acceptance
  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [3:0] fc, be, input logic bu,
                     input logic [31:0] d, output logic [1:0] rs,
                     output logic [31:0] rd);
    @(posedge core_clk);
    {host_req, host_wr, host_addr, host_fc} <= {1'h1, w, a, fc};
    {host_be, host_burst, host_wdata} <= {be, bu, d};
    @(posedge core_clk);
    host_req <= 1'h0;
    host_wdata <= ~d;
    @(posedge core_clk);
    rs = {host_ack, host_err};
    rd = host_rdata;
  endtask
endmodule

// file: dv/rsm_top_tb.sv
// Self-checking bench for strap modes and keyed base unlock
`timescale 1ns/10ps
module rsm_top_tb;
  logic        core_clk = 1'h0, rst = 1'h1, bus_width_strap = 1'h1;
  logic [2:0]  cfg_strap = 3'h0;
  logic        host_req, host_wr, host_burst, base_unlock_pin_n;
  logic        host_ack, host_err, slave_mode_r, core_enable_r;
  logic        base_relocated_r, bus_width16_r, low_lanes_unused_r;
  logic        bus_req_oe_r, bus_grant_oe_r, dma_bus_allow_r, unlock_sel_r;
  logic [23:0] host_addr;
  logic [3:0]  host_fc, host_be;
  logic [31:0] host_wdata, host_rdata, rd;
  logic [1:0]  boot_cs_width_r, rs;
  int          err_count = 0, checks = 0;
  rsm_top rsm_top_i (
    .core_clk           (core_clk),
    .rst                (rst),
    .cfg_strap          (cfg_strap),
    .bus_width_strap    (bus_width_strap),
    .base_unlock_pin_n  (base_unlock_pin_n),
    .host_req           (host_req),
    .host_wr            (host_wr),
    .host_addr          (host_addr),
    .host_fc            (host_fc),
    .host_be            (host_be),
    .host_burst         (host_burst),
    .host_wdata         (host_wdata),
    .host_ack           (host_ack),
    .host_err           (host_err),
    .host_rdata         (host_rdata),
    .slave_mode_r       (slave_mode_r),
    .core_enable_r      (core_enable_r),
    .boot_cs_width_r    (boot_cs_width_r),
    .base_relocated_r   (base_relocated_r),
    .bus_width16_r      (bus_width16_r),
    .low_lanes_unused_r (low_lanes_unused_r),
    .bus_req_oe_r       (bus_req_oe_r),
    .bus_grant_oe_r     (bus_grant_oe_r),
    .dma_bus_allow_r    (dma_bus_allow_r),
    .unlock_sel_r       (unlock_sel_r)
  );
  rsm_host_model rsm_host_model_i (
    .core_clk          (core_clk),
    .host_ack          (host_ack),
    .host_err          (host_err),
    .host_rdata        (host_rdata),
    .host_req          (host_req),
    .host_wr           (host_wr),
    .host_burst        (host_burst),
    .base_unlock_pin_n (base_unlock_pin_n),
    .host_addr         (host_addr),
    .host_fc           (host_fc),
    .host_be           (host_be),
    .host_wdata        (host_wdata)
  );
  always #4 core_clk = ~core_clk;
  // ******
  // Shared tasks
  // ******
  task chk(string n, logic [33:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task rstart(logic [2:0] c, logic w);
    @(posedge core_clk);
    {rst, cfg_strap, bus_width_strap} <= {1'h1, c, w};
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task io(logic w, logic [23:0] a, logic [3:0] fc, be, logic bu,
          logic [31:0] d);
    rsm_host_model_i.acc(w, a, fc, be, bu, d, rs, rd);
  endtask
  // ******
  // Scenarios
  // ******
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      rstart(i[2:0], 1'h1);
      chk("slave", slave_mode_r, 8'h4f >> i & 1);
      chk("cs", boot_cs_width_r, 16'h4bed >> 2*i & 3);
      chk("core", core_enable_r, !(8'h4f >> i & 1));
      chk("reloc", base_relocated_r, i == 6);
      chk("dma", dma_bus_allow_r, 1);
      chk("arb", {bus_req_oe_r, bus_grant_oe_r},
          1 + (8'h47 >> i & 1));
      cfg_strap <= ~i[2:0];
      repeat (3) @(posedge core_clk);
      chk("latch", boot_cs_width_r, 16'h4bed >> 2*i & 3);
    end
    rstart(3'h4, 1'h0);
    chk("w16", {bus_width16_r, low_lanes_unused_r}, 3);
    rstart(3'h5, 1'h1);
    chk("w32", bus_width16_r, 0);
    $display("modes done");
  endtask
  task t_plain;
    rstart(3'h0, 1'h1);
    io(0, 24'h03ff00, 4'h7, 4'hf, 0, 0);
    chk("rd0", {rs, rd}, {2'h2, 32'h0});
    io(1, 24'h03ff00, 4'h7, 4'hf, 0, 32'h12345678);
    io(0, 24'h03ff00, 4'h7, 4'hf, 0, 0);
    chk("rd1", {rs, rd}, {2'h2, 32'h12344278});
    io(0, 24'h03ff00, 4'h7, 4'hf, 1, 0);
    chk("burst", rs, 1);
    io(0, 24'h03ff00, 4'h5, 4'hf, 0, 0);
    chk("fc", rs, 1);
    io(1, 24'h03ff08, 4'h7, 4'hf, 0, 32'hfffffffe);
    chk("nounlk", {rs, unlock_sel_r}, 2);
    $display("plain done");
  endtask
  task t_unlock;
    rstart(3'h6, 1'h1);
    io(0, 24'h03ff04, 4'h7, 4'hf, 0, 0);
    chk("locked", rs, 1);
    io(0, 24'h03ff00, 4'h7, 4'hf, 0, 0);
    chk("defoff", rs, 1);
    io(1, 24'h03ff08, 4'h7, 4'hf, 0, 32'hffffffff);
    chk("pinhi", unlock_sel_r, 0);
    io(1, 24'h03ff08, 4'h7, 4'hf, 0, 32'h7ffffffe);
    chk("bit31", unlock_sel_r, 0);
    io(1, 24'h03ff08, 4'h7, 4'hf, 0, 32'hfffffffe);
    chk("sel", unlock_sel_r, 1);
    io(0, 24'h03ff08, 4'h7, 4'hf, 0, 0);
    chk("selrd", {rs, rd}, {2'h2, 32'h80000000});
    io(0, 24'h03ff04, 4'h5, 4'hf, 0, 0);
    chk("fc", rs, 1);
    io(1, 24'h03ff04, 4'h7, 4'he, 0, 32'h00aa0000);
    chk("hi", {rs, unlock_sel_r}, 5);
    io(0, 24'h03ff04, 4'h7, 4'hf, 0, 0);
    chk("rdalt", {rs, rd}, {2'h2, 32'h00aa0000});
    io(1, 24'h03ff04, 4'h7, 4'hf, 0, 32'hffffe001);
    chk("lo", {rs, unlock_sel_r}, 4);
    io(0, 24'h03ff04, 4'h7, 4'hf, 0, 0);
    chk("relock", rs, 1);
    $display("unlock done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence and hang guard
  initial begin
    t_modes;
    t_plain;
    t_unlock;
    close_out;
  end
  initial begin
    #60000;
    err_count++;
    close_out;
  end
endmodule
